// ---- design/dgp_consts.vh ----
// Constants for the dual general-purpose pin port block.
// Assumes inclusion by bare name from the design file only.
`ifndef DGP_CONSTS_VH
`define DGP_CONSTS_VH

// =====================================================================
// Register offsets
// =====================================================================
`define DGP_ADDR_W              8
`define DGP_OFS_PORT0_DATA      8'h00
`define DGP_OFS_PORT1_DATA      8'h01
`define DGP_OFS_PORT0_SEL_LOW   8'h0A
`define DGP_OFS_PORT0_SEL_HIGH  8'h0B
`define DGP_OFS_PORT1_SEL_LOW   8'h0C
`define DGP_OFS_PORT1_SEL_HIGH  8'h0D
`define DGP_OFS_IRQ_STATUS      8'h10
`define DGP_OFS_IRQ_MASK        8'h11
`define DGP_OFS_IRQ_STATUS1     8'h12
`define DGP_OFS_IRQ_MASK1       8'h13

// =====================================================================
// Reset values and field codes
// =====================================================================
`define DGP_RST_BYTE            8'h00
`define DGP_RST_STATUS          16'h0000
`define DGP_RD_ZERO             8'h00
`define DGP_SMALL_PORT1_MASK    8'h03
`define DGP_FULL_PORT1_MASK     8'hFF

// Drive strength codes reported per pin.
`define DGP_DRV_HIZ             3'h0
`define DGP_DRV_SINK_LOW        3'h1
`define DGP_DRV_SINK_MED        3'h2
`define DGP_DRV_SINK_HIGH       3'h3
`define DGP_DRV_HIGH            3'h4
`define DGP_DRV_PULLUP          3'h5

`endif

// ---- design/dgp_port.v ----
// Two general-purpose pin ports with per-pin drive selection.
// Assumes a synchronous register port from the core and pad cells that
// turn the per-pin enable, pull-up, sink and threshold controls into levels.
`timescale 1ns/100ps
`default_nettype none
`include "dgp_consts.vh"

// Functional notes
// RULE_01: Port zero eight pins; port one two or eight.
// RULE_02: Data write stores outputs; read returns pin levels.
// RULE_03: Each pin driven by data plus two selects.
// RULE_04: Reset clears data and selects: all high-impedance.
// RULE_05: Both selects zero: pin undriven, reads external.
// RULE_06: TTL only when selects zero, data one.
// RULE_07: High select only, data zero: weak sink.
// RULE_08: Low select only, data zero: medium sink.
// RULE_09: Both selects, data zero: strongest sink.
// RULE_10: Low select, data one: drive high.
// RULE_11: High select only, data one: resistive pull-up.
// RULE_12: Firmware toggles low select for open drain.
// RULE_13: Each pin selectable as interrupt source.
// RULE_14: Data registers at 0x00, 0x01, read/write.
// RULE_15: Port zero selects at 0x0A, 0x0B, write-only.
// RULE_16: Port one selects at 0x0C, 0x0D, write-only.
// RULE_17: Select reads zero; absent pins have no effect.
module dgp_port #(
    parameter LARGE_PACKAGE = 1
) (
    input  wire        core_clk_i,
    input  wire        rst_b_i,
    input  wire        clk_en_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire [15:0] pin_level_i,
    output wire [15:0] pin_drive_b_o,
    output wire [15:0] pin_drive_high_o,
    output wire [15:0] pin_pullup_o,
    output wire [47:0] pin_strength_o,
    output wire [15:0] pin_ttl_o,
    output wire        irq_o
);

    // =================================================================
    // Pin mode decode
    // =================================================================
    // Returns {drive_enable, level_high, pullup, ttl, strength[2:0]}.
    function [6:0] dgp_decode;
        input data;
        input sel_low;
        input sel_high;
        begin
            case ({sel_high, sel_low, data})
                3'b000: dgp_decode = {4'b0000, `DGP_DRV_HIZ};        // RULE_05 RULE_06
                3'b001: dgp_decode = {4'b0001, `DGP_DRV_HIZ};        // RULE_06
                3'b100: dgp_decode = {4'b1000, `DGP_DRV_SINK_LOW};   // RULE_07
                3'b010: dgp_decode = {4'b1000, `DGP_DRV_SINK_MED};   // RULE_08
                3'b110: dgp_decode = {4'b1000, `DGP_DRV_SINK_HIGH};  // RULE_09
                3'b011: dgp_decode = {4'b1100, `DGP_DRV_HIGH};       // RULE_10
                3'b111: dgp_decode = {4'b1100, `DGP_DRV_HIGH};       // RULE_10
                default: dgp_decode = {4'b0010, `DGP_DRV_PULLUP};    // RULE_11
            endcase
        end
    endfunction

    // =================================================================
    // Registers
    // =================================================================
    reg  [7:0]  port_zero_pin_data;
    reg  [7:0]  port_one_pin_data;
    reg  [7:0]  port_zero_drive_select_low;
    reg  [7:0]  port_zero_drive_select_high;
    reg  [7:0]  port_one_drive_select_low;
    reg  [7:0]  port_one_drive_select_high;
    reg  [15:0] irq_status;
    reg  [15:0] irq_mask;
    reg  [15:0] pin_level_q;
    wire [7:0]  port1_mask;
    wire [15:0] data_all;
    wire [15:0] sel_low_all;
    wire [15:0] sel_high_all;
    wire [15:0] pin_present;
    wire [15:0] pin_edge;
    wire [15:0] status_clr;
    wire [15:0] status_set;
    reg  [7:0]  next_rdata;

    // Pins absent on the small package are forced to high-impedance.
    assign port1_mask   = (LARGE_PACKAGE != 0) ? `DGP_FULL_PORT1_MASK
                                               : `DGP_SMALL_PORT1_MASK;  // RULE_01
    assign pin_present  = {port1_mask, `DGP_FULL_PORT1_MASK};            // RULE_17
    // Data bits of absent pins are masked too, so they cannot select TTL.
    assign data_all     = {port_one_pin_data, port_zero_pin_data} & pin_present;
    assign sel_low_all  = {port_one_drive_select_low, port_zero_drive_select_low}
                          & pin_present;
    assign sel_high_all = {port_one_drive_select_high, port_zero_drive_select_high}
                          & pin_present;

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            port_zero_pin_data          <= `DGP_RST_BYTE;  // RULE_04
            port_one_pin_data           <= `DGP_RST_BYTE;
            port_zero_drive_select_low  <= `DGP_RST_BYTE;
            port_zero_drive_select_high <= `DGP_RST_BYTE;
            port_one_drive_select_low   <= `DGP_RST_BYTE;
            port_one_drive_select_high  <= `DGP_RST_BYTE;
            irq_mask                    <= `DGP_RST_STATUS;
        end else if (clk_en_i && reg_wr_i) begin
            if (reg_addr_i == `DGP_OFS_PORT0_DATA) begin
                port_zero_pin_data <= reg_wdata_i;            // RULE_02 RULE_14
            end else if (reg_addr_i == `DGP_OFS_PORT1_DATA) begin
                port_one_pin_data <= reg_wdata_i;             // RULE_14
            end else if (reg_addr_i == `DGP_OFS_PORT0_SEL_LOW) begin
                port_zero_drive_select_low <= reg_wdata_i;    // RULE_15
            end else if (reg_addr_i == `DGP_OFS_PORT0_SEL_HIGH) begin
                port_zero_drive_select_high <= reg_wdata_i;   // RULE_15
            end else if (reg_addr_i == `DGP_OFS_PORT1_SEL_LOW) begin
                port_one_drive_select_low <= reg_wdata_i;     // RULE_16
            end else if (reg_addr_i == `DGP_OFS_PORT1_SEL_HIGH) begin
                port_one_drive_select_high <= reg_wdata_i;    // RULE_16
            end else if (reg_addr_i == `DGP_OFS_IRQ_MASK) begin
                irq_mask[7:0] <= reg_wdata_i;                 // RULE_13
            end else if (reg_addr_i == `DGP_OFS_IRQ_MASK1) begin
                irq_mask[15:8] <= reg_wdata_i & port1_mask;
            end
        end
    end

    // =================================================================
    // Per-pin drive outputs
    // =================================================================
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_pin
            wire [6:0] mode;
            assign mode = dgp_decode(data_all[g], sel_low_all[g], sel_high_all[g]); // RULE_03
            assign pin_drive_b_o[g]       = ~mode[6];
            assign pin_drive_high_o[g]    = mode[5];
            assign pin_pullup_o[g]        = mode[4];
            assign pin_ttl_o[g]           = mode[3];
            assign pin_strength_o[3*g+:3] = mode[2:0];
        end
    endgenerate

    // =================================================================
    // Pin change interrupts
    // =================================================================
    // A change on any present pin sets its status bit; a set in the same
    // cycle as a write-one clear is kept so no event is lost.
    assign pin_edge   = (pin_level_i ^ pin_level_q) & pin_present;
    assign status_clr = (clk_en_i && reg_wr_i && reg_addr_i == `DGP_OFS_IRQ_STATUS)
                        ? {8'h00, reg_wdata_i}
                        : ((clk_en_i && reg_wr_i
                            && reg_addr_i == `DGP_OFS_IRQ_STATUS1)
                           ? {reg_wdata_i, 8'h00} : 16'h0000);
    assign status_set = pin_edge;

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            irq_status  <= `DGP_RST_STATUS;
            pin_level_q <= `DGP_RST_STATUS;
        end else if (clk_en_i) begin
            pin_level_q <= pin_level_i;
            irq_status  <= (irq_status & ~status_clr) | status_set;  // RULE_13
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // =================================================================
    // Read path
    // =================================================================
    always @* begin
        if (reg_addr_i == `DGP_OFS_PORT0_DATA) begin
            next_rdata = pin_level_i[7:0];                 // RULE_02
        end else if (reg_addr_i == `DGP_OFS_PORT1_DATA) begin
            next_rdata = pin_level_i[15:8] & port1_mask;   // RULE_01
        end else if (reg_addr_i == `DGP_OFS_IRQ_STATUS) begin
            next_rdata = irq_status[7:0];
        end else if (reg_addr_i == `DGP_OFS_IRQ_STATUS1) begin
            next_rdata = irq_status[15:8];
        end else if (reg_addr_i == `DGP_OFS_IRQ_MASK) begin
            next_rdata = irq_mask[7:0];
        end else if (reg_addr_i == `DGP_OFS_IRQ_MASK1) begin
            next_rdata = irq_mask[15:8];
        end else begin
            next_rdata = `DGP_RD_ZERO;                     // RULE_17
        end
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= `DGP_RD_ZERO;
        end else if (clk_en_i) begin
            reg_rdata_o <= reg_rd_i ? next_rdata : `DGP_RD_ZERO;
        end
    end

endmodule // dgp_port
`default_nettype wire

// ---- verification/dgp_port_monitor.sv ----
// Assertions on the pin port block's register read port and pad controls.
// Assumes one clock domain and clk_en_i held high.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Checker
// ==========================================================
module dgp_port_checker (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [15:0] pin_drive_b_o,
    input wire logic [15:0] pin_drive_high_o,
    input wire logic [15:0] pin_pullup_o,
    input wire logic [47:0] pin_strength_o,
    input wire logic [15:0] pin_ttl_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_sel_rd;
        reg_rd_i && reg_addr_i >= 8'h0a && reg_addr_i <= 8'h0d;
    endsequence
    property p_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
    property p_sel_zero; s_sel_rd |=> reg_rdata_o == 8'h00; endproperty
    property p_hi_drv; (pin_drive_high_o & pin_drive_b_o) == 16'h0000; endproperty
    property p_pull; (pin_pullup_o & ~pin_drive_b_o) == 16'h0000; endproperty
    property p_ttl; (pin_ttl_o & ~pin_drive_b_o) == 16'h0000; endproperty
    property p_ttl_pull; (pin_ttl_o & pin_pullup_o) == 16'h0000; endproperty
    property p_rst;
        $rose(rst_b_i) |-> pin_drive_b_o == 16'hffff && pin_strength_o == 48'h0;
    endproperty
    property p_hold; !$past(reg_wr_i) |-> $stable(pin_strength_o); endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    a_sel_zero: assert property (p_sel_zero) else $error("select read nonzero");
    a_hi_drv: assert property (p_hi_drv) else $error("high drive undriven");
    a_pull: assert property (p_pull) else $error("pullup while driven");
    a_ttl: assert property (p_ttl) else $error("ttl while driven");
    a_ttl_pull: assert property (p_ttl_pull) else $error("ttl with pullup");
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    a_hold: assert property (p_hold) else $error("drive changed without write");
endmodule // dgp_port_checker
bind dgp_port dgp_port_checker u_chk (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .pin_drive_b_o, .pin_drive_high_o, .pin_pullup_o,
    .pin_strength_o, .pin_ttl_o);
`default_nettype wire

// ---- verification/dgp_board.sv ----
// Board model: resolves each pin from the pad controls and an outside level.
// Assumes ext_i is a weak outside source that any active drive overrides.
`timescale 1ns/100ps
`default_nettype none
module dgp_board (
    input  wire logic [15:0] drive_b_i,
    input  wire logic [15:0] drive_high_i,
    input  wire logic [15:0] pullup_i,
    input  wire logic [15:0] ext_i,
    output wire logic [15:0] level_o
);
    // Sinking pins read low; released pins fall to the pull-up or outside level.
    assign level_o = (~drive_b_i & drive_high_i) | (drive_b_i & (pullup_i | ext_i));
endmodule // dgp_board
`default_nettype wire

// ---- verification/dgp_port_bench.sv ----
// Self-checking bench for the pin port block with the board model.
// Assumes the large package; clk_en_i is held high except while t_freeze drives it low.
`timescale 1ns/100ps
`default_nettype none
module dgp_port_bench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        en = 1'b1;
    logic [15:0] ext = 16'h5a3c;
    logic [7:0]  rdata;
    logic [15:0] lvl, drv_b, drv_hi, pull, ttl;
    logic [47:0] str;
    logic        irq;
    int          err_count = 0;
    int          total_checks = 0;
    always #20 clk = ~clk;
    dgp_port dut (.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .pin_level_i(lvl), .pin_drive_b_o(drv_b), .pin_drive_high_o(drv_hi),
        .pin_pullup_o(pull), .pin_strength_o(str), .pin_ttl_o(ttl), .irq_o(irq));
    dgp_board u_board (.drive_b_i(drv_b), .drive_high_i(drv_hi), .pullup_i(pull),
        .ext_i(ext), .level_o(lvl));
    // ==========================================================
    // Bus and compare tasks
    // ==========================================================
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(48'(rdata), 48'(e));
    endtask
    task automatic end_of_test;
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk(48'(drv_b), 48'hffff);
        chk(str | 48'(ttl), 48'h0);
    endtask
    task automatic t_table;
        logic [2:0] e;
        logic [7:0] v;
        for (int c = 0; c < 8; c++) begin
            e = 24'h8e_9880 >> (3 * c);
            wr_reg(8'h00, {8{c[0]}});
            wr_reg(8'h01, {8{c[0]}});
            wr_reg(8'h0a, {8{c[1]}});
            wr_reg(8'h0b, {8{c[2]}});
            wr_reg(8'h0c, {8{c[1]}});
            wr_reg(8'h0d, {8{c[2]}});
            repeat (3) @(posedge clk);
            chk(str, {16{e}});
            chk(48'(drv_b), 48'({16{e == 3'h0 || e == 3'h5}}));
            chk(48'(ttl), 48'({16{c == 1}}));
            chk(48'({pull, drv_hi}), 48'({{16{e == 3'h5}}, {16{e == 3'h4}}}));
            v = (e == 3'h4 || e == 3'h5) ? 8'hff : 8'h00;
            rd_reg(8'h00, (e == 3'h0) ? ext[7:0] : v);
            rd_reg(8'h01, (e == 3'h0) ? ext[15:8] : v);
        end
    endtask
    task automatic t_selects;
        for (int a = 8'h0a; a < 8'h0e; a++)
            rd_reg(8'(a), 8'h00);
        rd_reg(8'h20, 8'h00);
    endtask
    // A write while the clock enable is low must leave every pin released.
    task automatic t_freeze;
        @(posedge clk);
        en <= 1'b0;
        wr_reg(8'h0a, 8'hff);
        #1 chk(48'(drv_b), 48'hffff);
        @(posedge clk);
        en <= 1'b1;
    endtask
    task automatic t_irq;
        wr_reg(8'h10, 8'hff);
        wr_reg(8'h12, 8'hff);
        ext <= ext ^ 16'h0101;
        repeat (4) @(posedge clk);
        rd_reg(8'h10, 8'h01);
        rd_reg(8'h12, 8'h01);
        chk(48'(irq), 48'h0);
        wr_reg(8'h13, 8'h01);
        #1 chk(48'(irq), 48'h1);
        wr_reg(8'h12, 8'h01);
        #1 chk(48'(irq), 48'h0);
    endtask
    // The watchdog span is far above the few hundred cycles the scenarios need.
    initial begin
        #(40 * 5000);
        err_count++;
        end_of_test();
    end
    initial begin
        t_reset();
        t_table();
        t_selects();
        t_reset();
        t_freeze();
        t_irq();
        end_of_test();
    end
endmodule // dgp_port_bench
`default_nettype wire
